// ---- design/pclu_core.sv ----
// Program counter load unit with stack access and debug shadow bank
`timescale 1ns/1ps
// Function
// - 15-bit PC, low byte readable and writable
// - Upper PC bits only via high latch
// - Any reset clears the whole PC
// - Low byte write loads upper bits from latch
// - Computed jump by adding to PC low byte
// - Call: operand bits 10:0, latch bits 6:3
// - Computed call: work register and high latch
// - Register branch: PC plus one plus W
// - Operand branch: PC plus one plus signed
// - Branches use incremented PC, cross boundaries freely
// - Shadow copies of normal core register context
// - Dual-access regs for user; others debug-only
// - Call increments pointer, then stores return PC
// - Return reloads PC, then decrements pointer
module pclu_core
  import pclu_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic op_valid_in,
  input wire pclu_op_t op_code_in,
  input wire logic [10:0] op_operand_in,
  input wire logic [7:0] w_value_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic [7:0] reg_wr_data_in,
  input wire logic reg_rd_en_in,
  output logic [7:0] reg_rd_data_out,
  input wire logic dbg_mode_in,
  input wire logic dbg_enter_in,
  input wire logic dbg_exit_in,
  input wire logic [2:0] live_status_in,
  input wire logic [4:0] live_bank_in,
  input wire logic [15:0] live_ptr0_in,
  input wire logic [15:0] live_ptr1_in,
  output logic [14:0] pc_out,
  output logic [6:0] pc_high_latch_out,
  output logic [4:0] stack_pointer_out,
  output logic restore_valid_out,
  output logic [2:0] restore_status_out,
  output logic [7:0] restore_w_out,
  output logic [4:0] restore_bank_out,
  output logic [15:0] restore_ptr0_out,
  output logic [15:0] restore_ptr1_out
);

  logic [14:0] pc_q;
  logic [14:0] pc_d;
  logic [6:0] pc_high_latch_q;
  logic [6:0] pc_high_latch_d;
  logic [4:0] stack_pointer_q;
  logic [4:0] stack_pointer_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic restore_valid_q;
  logic restore_valid_d;

  logic [14:0] stack_mem [PCLU_STACK_DEPTH];
  logic stack_wr_en;
  logic [3:0] stack_wr_addr;
  logic [14:0] stack_wr_data;
  logic [14:0] tos_value;

  logic [14:0] pc_inc;
  logic [14:0] bra_offset;
  logic [6:0] core_addr;
  logic is_core_reg;
  logic wr_pc_low;
  logic wr_latch;
  logic wr_sp;
  logic wr_tos_low;
  logic wr_tos_high;
  logic [11:0] shadow_rel;
  logic shadow_hit;
  logic shadow_allowed;

  logic [7:0] shadow_live [PCLU_SHADOW_N];
  logic [7:0] shadow_val [PCLU_SHADOW_N];
  logic [PCLU_SHADOW_N-1:0] shadow_wr;

  // Address decode
  assign core_addr = reg_addr_in[6:0] & PCLU_CORE_MASK;
  assign is_core_reg = (reg_addr_in[11:7] == 5'h00);
  assign wr_pc_low = reg_wr_en_in && is_core_reg && (core_addr == PCLU_PC_LOW_OFS);
  assign wr_latch = reg_wr_en_in && is_core_reg && (core_addr == PCLU_PC_LATCH_OFS);
  assign wr_sp = reg_wr_en_in && (reg_addr_in == PCLU_STACK_POINTER_OFS);
  assign wr_tos_low = reg_wr_en_in && (reg_addr_in == PCLU_TOS_LOW_OFS);
  assign wr_tos_high = reg_wr_en_in && (reg_addr_in == PCLU_TOS_HIGH_OFS);
  assign shadow_rel = reg_addr_in - PCLU_SHADOW_BASE;
  assign shadow_hit = (reg_addr_in >= PCLU_SHADOW_BASE) && (shadow_rel < 12'h008);
  // Bank and latch shadows are reachable only while the debug executive runs
  assign shadow_allowed = dbg_mode_in ||
    ((shadow_rel[2:0] != 3'(PCLU_SH_BANK)) &&
     (shadow_rel[2:0] != 3'(PCLU_SH_LATCH)));

  // Top of stack as seen through the access registers
  assign tos_value = stack_mem[stack_pointer_q[3:0]];

  // Branch base is the already incremented PC
  assign pc_inc = pc_q + 15'h0001;
  assign bra_offset = {{(PCLU_PC_W-PCLU_BRA_W){op_operand_in[8]}}, op_operand_in[8:0]};

  // Live normal context feeding the shadow bank
  assign shadow_live[PCLU_SH_STATUS] = {5'h00, live_status_in};
  assign shadow_live[PCLU_SH_WORK] = w_value_in;
  assign shadow_live[PCLU_SH_BANK] = {3'h0, live_bank_in};
  assign shadow_live[PCLU_SH_LATCH] = {1'b0, pc_high_latch_q};
  assign shadow_live[PCLU_SH_PTR0_LOW] = live_ptr0_in[7:0];
  assign shadow_live[PCLU_SH_PTR0_HIGH] = live_ptr0_in[15:8];
  assign shadow_live[PCLU_SH_PTR1_LOW] = live_ptr1_in[7:0];
  assign shadow_live[PCLU_SH_PTR1_HIGH] = live_ptr1_in[15:8];

  // Shadow bank of the normal context
  genvar gi;
  generate
    for (gi = 0; gi < PCLU_SHADOW_N; gi++)
    begin : g_shadow
      localparam logic [7:0] CELL_MASK =
        (gi == PCLU_SH_STATUS) ? PCLU_STATUS_MASK :
        (gi == PCLU_SH_BANK) ? PCLU_BANK_MASK :
        (gi == PCLU_SH_LATCH) ? PCLU_LATCH_MASK : PCLU_BYTE_MASK;
      assign shadow_wr[gi] = reg_wr_en_in && shadow_hit && shadow_allowed &&
        (shadow_rel[2:0] == 3'(gi));
      pclu_shadow_cell #(
        .MASK(CELL_MASK)
      ) u_cell (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .capture_in(dbg_enter_in),
        .live_in(shadow_live[gi]),
        .wr_en_in(shadow_wr[gi]),
        .wr_data_in(reg_wr_data_in),
        .value_out(shadow_val[gi])
      );
    end
  endgenerate

  // Program counter, stack pointer and stack write next values
  always_comb
  begin
    pc_d = pc_q;
    stack_pointer_d = stack_pointer_q;
    stack_wr_en = 1'b0;
    stack_wr_addr = stack_pointer_q[3:0];
    stack_wr_data = pc_inc;
    if (wr_pc_low)
    begin
      // Covers any write with the low byte as destination, computed jumps included
      pc_d = {pc_high_latch_q, reg_wr_data_in};
    end
    else if (op_valid_in)
    begin
      unique case (op_code_in)
        PCLU_OP_STEP:
        begin
          pc_d = pc_inc;
        end
        PCLU_OP_GOTO:
        begin
          pc_d = {pc_high_latch_q[6:3], op_operand_in};
        end
        PCLU_OP_CALL:
        begin
          pc_d = {pc_high_latch_q[6:3], op_operand_in};
          stack_pointer_d = stack_pointer_q + 5'h01;
          stack_wr_en = 1'b1;
          stack_wr_addr = stack_pointer_d[3:0];
        end
        PCLU_OP_COMPUTED_CALL_INSTR:
        begin
          pc_d = {pc_high_latch_q, w_value_in};
          stack_pointer_d = stack_pointer_q + 5'h01;
          stack_wr_en = 1'b1;
          stack_wr_addr = stack_pointer_d[3:0];
        end
        PCLU_OP_BRW:
        begin
          pc_d = pc_inc + {7'h00, w_value_in};
        end
        PCLU_OP_BRA:
        begin
          pc_d = pc_inc + bra_offset;
        end
        PCLU_OP_RETURN:
        begin
          pc_d = tos_value;
          stack_pointer_d = stack_pointer_q - 5'h01;
        end
        default:
        begin
          pc_d = pc_inc;
        end
      endcase
    end
    if (wr_sp && shadow_allowed)
    begin
      stack_pointer_d = reg_wr_data_in[4:0];
    end
    if (wr_tos_low)
    begin
      stack_wr_en = 1'b1;
      stack_wr_addr = stack_pointer_q[3:0];
      stack_wr_data = {tos_value[14:8], reg_wr_data_in};
    end
    else if (wr_tos_high)
    begin
      stack_wr_en = 1'b1;
      stack_wr_addr = stack_pointer_q[3:0];
      stack_wr_data = {reg_wr_data_in[6:0], tos_value[7:0]};
    end
  end

  // High-byte latch next value; restore on debug exit beats a software write
  always_comb
  begin
    pc_high_latch_d = pc_high_latch_q;
    if (wr_latch)
    begin
      pc_high_latch_d = reg_wr_data_in[6:0];
    end
    if (dbg_exit_in)
    begin
      pc_high_latch_d = shadow_val[PCLU_SH_LATCH][6:0];
    end
  end

  // Register read data, captured one cycle after the read strobe
  always_comb
  begin
    rd_data_d = 8'h00;
    if (reg_rd_en_in)
    begin
      if (is_core_reg && (core_addr == PCLU_PC_LOW_OFS))
      begin
        rd_data_d = pc_q[7:0];
      end
      else if (is_core_reg && (core_addr == PCLU_PC_LATCH_OFS))
      begin
        rd_data_d = {1'b0, pc_high_latch_q};
      end
      else if (shadow_hit && shadow_allowed)
      begin
        rd_data_d = shadow_val[shadow_rel[2:0]];
      end
      else if (reg_addr_in == PCLU_STACK_POINTER_OFS)
      begin
        rd_data_d = {3'h0, stack_pointer_q};
      end
      else if (reg_addr_in == PCLU_TOS_LOW_OFS)
      begin
        rd_data_d = tos_value[7:0];
      end
      else if (reg_addr_in == PCLU_TOS_HIGH_OFS)
      begin
        rd_data_d = {1'b0, tos_value[14:8]};
      end
    end
  end

  always_comb
  begin
    restore_valid_d = dbg_exit_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      pc_q <= PCLU_PC_RESET;
      stack_pointer_q <= PCLU_SP_RESET;
    end
    else
    begin
      pc_q <= pc_d;
      stack_pointer_q <= stack_pointer_d;
    end
  end

  // High-byte latch register
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      pc_high_latch_q <= PCLU_LATCH_RESET;
    end
    else
    begin
      pc_high_latch_q <= pc_high_latch_d;
    end
  end

  // Read data register
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  // Restore strobe register
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      restore_valid_q <= 1'b0;
    end
    else
    begin
      restore_valid_q <= restore_valid_d;
    end
  end

  // Stack contents are left undefined by reset
  always_ff @(posedge clk_sys_in)
  begin
    if (stack_wr_en)
    begin
      stack_mem[stack_wr_addr] <= stack_wr_data;
    end
  end

  assign pc_out = pc_q;
  assign pc_high_latch_out = pc_high_latch_q;
  assign stack_pointer_out = stack_pointer_q;
  assign reg_rd_data_out = rd_data_q;
  assign restore_valid_out = restore_valid_q;
  assign restore_status_out = shadow_val[PCLU_SH_STATUS][2:0];
  assign restore_w_out = shadow_val[PCLU_SH_WORK];
  assign restore_bank_out = shadow_val[PCLU_SH_BANK][4:0];
  assign restore_ptr0_out = {shadow_val[PCLU_SH_PTR0_HIGH], shadow_val[PCLU_SH_PTR0_LOW]};
  assign restore_ptr1_out = {shadow_val[PCLU_SH_PTR1_HIGH], shadow_val[PCLU_SH_PTR1_LOW]};

endmodule

// ---- design/pclu_pkg.sv ----
// Shared constants and types for the program counter load unit
package pclu_pkg;

  localparam int PCLU_PC_W = 15;
  localparam int PCLU_LO_W = 8;
  localparam int PCLU_HI_W = 7;
  localparam int PCLU_SP_W = 5;
  localparam int PCLU_STACK_DEPTH = 16;
  localparam int PCLU_STACK_AW = 4;
  localparam int PCLU_CALL_W = 11;
  localparam int PCLU_BRA_W = 9;
  localparam int PCLU_SHADOW_N = 8;

  // Core registers decoded only while address bits 11:7 are zero, matched on the low seven address bits
  localparam logic [6:0] PCLU_CORE_MASK = 7'h7f;
  localparam logic [6:0] PCLU_PC_LOW_OFS = 7'h02;
  localparam logic [6:0] PCLU_PC_LATCH_OFS = 7'h0a;

  // Debug bank registers
  localparam logic [11:0] PCLU_SHADOW_BASE = 12'hfe4;
  localparam logic [11:0] PCLU_STATUS_SHADOW_OFS = 12'hfe4;
  localparam logic [11:0] PCLU_WORK_SHADOW_OFS = 12'hfe5;
  localparam logic [11:0] PCLU_BANK_SHADOW_OFS = 12'hfe6;
  localparam logic [11:0] PCLU_LATCH_SHADOW_OFS = 12'hfe7;
  localparam logic [11:0] PCLU_PTR0_LOW_SHADOW_OFS = 12'hfe8;
  localparam logic [11:0] PCLU_PTR0_HIGH_SHADOW_OFS = 12'hfe9;
  localparam logic [11:0] PCLU_PTR1_LOW_SHADOW_OFS = 12'hfea;
  localparam logic [11:0] PCLU_PTR1_HIGH_SHADOW_OFS = 12'hfeb;
  localparam logic [11:0] PCLU_STACK_POINTER_OFS = 12'hfed;
  localparam logic [11:0] PCLU_TOS_LOW_OFS = 12'hfee;
  localparam logic [11:0] PCLU_TOS_HIGH_OFS = 12'hfef;

  // Shadow slot indices, equal to offset minus the shadow base
  localparam int PCLU_SH_STATUS = 0;
  localparam int PCLU_SH_WORK = 1;
  localparam int PCLU_SH_BANK = 2;
  localparam int PCLU_SH_LATCH = 3;
  localparam int PCLU_SH_PTR0_LOW = 4;
  localparam int PCLU_SH_PTR0_HIGH = 5;
  localparam int PCLU_SH_PTR1_LOW = 6;
  localparam int PCLU_SH_PTR1_HIGH = 7;

  // Implemented bits of each shadow slot
  localparam logic [7:0] PCLU_STATUS_MASK = 8'h07;
  localparam logic [7:0] PCLU_BYTE_MASK = 8'hff;
  localparam logic [7:0] PCLU_BANK_MASK = 8'h1f;
  localparam logic [7:0] PCLU_LATCH_MASK = 8'h7f;

  // Reset values
  localparam logic [14:0] PCLU_PC_RESET = 15'h0000;
  localparam logic [6:0] PCLU_LATCH_RESET = 7'h00;
  localparam logic [4:0] PCLU_SP_RESET = 5'h1f;
  localparam logic [7:0] PCLU_SHADOW_RESET = 8'h00;

  typedef enum logic [2:0] {
    PCLU_OP_STEP,
    PCLU_OP_GOTO,
    PCLU_OP_CALL,
    PCLU_OP_COMPUTED_CALL_INSTR,
    PCLU_OP_BRW,
    PCLU_OP_BRA,
    PCLU_OP_RETURN
  } pclu_op_t;

endpackage

// ---- design/pclu_shadow_cell.sv ----
// One shadow register of the debug bank with capture and software write
`timescale 1ns/1ps
module pclu_shadow_cell
  import pclu_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
)
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic capture_in,
  input wire logic [7:0] live_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] value_out
);

  logic [7:0] value_q;
  logic [7:0] value_d;

  // Capture on debug entry wins over a software write in the same cycle
  always_comb
  begin
    value_d = value_q;
    if (capture_in)
    begin
      value_d = live_in & MASK;
    end
    else if (wr_en_in)
    begin
      value_d = wr_data_in & MASK;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      value_q <= PCLU_SHADOW_RESET;
    end
    else
    begin
      value_q <= value_d;
    end
  end

  assign value_out = value_q;

endmodule

// ---- tb/pclu_chk.sv ----
// Assertion checker bound to the program counter load unit
`timescale 1ns/1ps
module pclu_chk
  import pclu_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic op_valid_in,
  input wire pclu_op_t op_code_in,
  input wire logic [10:0] op_operand_in,
  input wire logic [7:0] w_value_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_en_in,
  input wire logic [7:0] reg_wr_data_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_rd_data_out,
  input wire logic dbg_mode_in,
  input wire logic [14:0] pc_out,
  input wire logic [6:0] pc_high_latch_out,
  input wire logic [4:0] stack_pointer_out
);
  logic [14:0] bra_off;
  assign bra_off = {{6{op_operand_in[8]}}, op_operand_in[8:0]};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence pcl_wr_s;
    reg_wr_en_in && reg_addr_in == 12'h002;
  endsequence
  // A same-cycle low byte write takes priority over the instruction
  sequence op_s(pclu_op_t k);
    op_valid_in && op_code_in == k && !(reg_wr_en_in && reg_addr_in == 12'h002);
  endsequence
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_b_in |=> pc_out == 15'h0000 && stack_pointer_out == 5'h1f)
    else $error("pc or stack pointer not cleared");
  low_write_a: assert property (pcl_wr_s |=>
    pc_out == {$past(pc_high_latch_out), $past(reg_wr_data_in)})
    else $error("low byte write did not load all bits");
  call_load_a: assert property (op_s(PCLU_OP_CALL) |=>
    pc_out == {$past(pc_high_latch_out[6:3]), $past(op_operand_in)}
    && stack_pointer_out == $past(stack_pointer_out) + 5'h01)
    else $error("call target or pointer wrong");
  computed_call_instr_load_a: assert property (op_s(PCLU_OP_COMPUTED_CALL_INSTR) |=>
    pc_out == {$past(pc_high_latch_out), $past(w_value_in)})
    else $error("computed call target wrong");
  brw_target_a: assert property (op_s(PCLU_OP_BRW) |=>
    pc_out == $past(pc_out) + 15'h0001 + {7'h00, $past(w_value_in)})
    else $error("register branch target wrong");
  bra_target_a: assert property (op_s(PCLU_OP_BRA) |=>
    pc_out == $past(pc_out) + 15'h0001 + $past(bra_off))
    else $error("operand branch target wrong");
  return_pop_a: assert property (op_s(PCLU_OP_RETURN) |=>
    stack_pointer_out == $past(stack_pointer_out) - 5'h01)
    else $error("return did not drop pointer");
  refuse_read_a: assert property (
    reg_rd_en_in && reg_addr_in == 12'hfe6 && !dbg_mode_in |=> reg_rd_data_out == 8'h00)
    else $error("debug only register readable by user");
endmodule
bind pclu_core pclu_chk u_pclu_chk (.*);

// ---- tb/pclu_partner.sv ----
// Instruction decoder and debug executive model facing the load unit
`timescale 1ns/1ps
module pclu_partner
  import pclu_pkg::*;
(
  input wire logic clk_sys_in,
  output logic op_valid_out,
  output pclu_op_t op_code_out,
  output logic [10:0] op_operand_out,
  output logic [7:0] w_value_out,
  output logic dbg_enter_out,
  output logic dbg_exit_out
);
  initial
  begin
    op_valid_out = 1'b0;
    op_code_out = PCLU_OP_STEP;
    op_operand_out = 11'h000;
    w_value_out = 8'h00;
    dbg_enter_out = 1'b0;
    dbg_exit_out = 1'b0;
  end
  // Released operand and W fields show the inverse so stale values cannot pass; the op code is left as issued
  task automatic issue(input pclu_op_t k, input logic [10:0] a, input logic [7:0] w);
    @(negedge clk_sys_in);
    op_code_out = k;
    op_operand_out = a;
    w_value_out = w;
    op_valid_out = 1'b1;
    @(negedge clk_sys_in);
    op_valid_out = 1'b0;
    op_operand_out = ~a;
    w_value_out = ~w;
  endtask
  task automatic dbg(input logic ent, input logic [7:0] w);
    @(negedge clk_sys_in);
    w_value_out = w;
    dbg_enter_out = ent;
    dbg_exit_out = ~ent;
    @(negedge clk_sys_in);
    dbg_enter_out = 1'b0;
    dbg_exit_out = 1'b0;
    w_value_out = ~w;
  endtask
endmodule

// ---- tb/pclu_core_tb_top.sv ----
// Self-checking bench for the program counter load unit
`timescale 1ns/1ps
module pclu_core_tb_top;
  import pclu_pkg::*;
  typedef struct packed {logic rd; logic [7:0] dat; logic [14:0] pc; logic [4:0] sp;} pclu_note_t;
  logic clk_sys_in, rst_b_in, op_valid_in, reg_wr_en_in, reg_rd_en_in, pend_q;
  logic dbg_mode_in, dbg_enter_in, dbg_exit_in, restore_valid_out;
  pclu_op_t op_code_in;
  logic [10:0] op_operand_in;
  logic [7:0] w_value_in, reg_wr_data_in, reg_rd_data_out, restore_w_out;
  logic [11:0] reg_addr_in;
  logic [2:0] live_status_in, restore_status_out;
  logic [4:0] live_bank_in, restore_bank_out, stack_pointer_out, sp_m;
  logic [15:0] live_ptr0_in, live_ptr1_in, restore_ptr0_out, restore_ptr1_out;
  logic [14:0] pc_out, pc_m;
  logic [6:0] pc_high_latch_out, lat_m, lsh_m;
  logic [14:0] stk [16];
  logic [31:0] r;
  int seed = 32'h425a0c33;
  int fail_count = 0;
  int checks_done = 0;
  pclu_note_t notes[$];
  pclu_note_t n;

  pclu_core u_pclu_core (.*);
  pclu_partner u_pclu_partner (.clk_sys_in(clk_sys_in), .op_valid_out(op_valid_in),
    .op_code_out(op_code_in), .op_operand_out(op_operand_in), .w_value_out(w_value_in),
    .dbg_enter_out(dbg_enter_in), .dbg_exit_out(dbg_exit_in));

  always #25 clk_sys_in = ~clk_sys_in;

  task automatic chk(input string nm, input logic [14:0] got, input logic [14:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_wr_data_in = d;
    reg_wr_en_in = 1'b1;
    if (a == 12'h002) pc_m = {lat_m, d};
    if (a == 12'h00a) lat_m = d[6:0];
    if (a == 12'hfed) sp_m = d[4:0];
    if (a == 12'hfe7 && dbg_mode_in) lsh_m = d[6:0];
    notes.push_back({1'b0, 8'h00, pc_m, sp_m});
    @(negedge clk_sys_in);
    reg_wr_en_in = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_rd_en_in = 1'b1;
    notes.push_back({1'b1, e, 15'h0000, 5'h00});
    @(negedge clk_sys_in);
    reg_rd_en_in = 1'b0;
  endtask
  task automatic op(input pclu_op_t k, input logic [10:0] a, input logic [7:0] w);
    case (k)
      PCLU_OP_CALL, PCLU_OP_COMPUTED_CALL_INSTR:
      begin
        sp_m = sp_m + 5'h01;
        stk[sp_m[3:0]] = pc_m + 15'h0001;
        pc_m = (k == PCLU_OP_CALL) ? {lat_m[6:3], a} : {lat_m, w};
      end
      PCLU_OP_BRW: pc_m = pc_m + 15'h0001 + {7'h00, w};
      PCLU_OP_BRA: pc_m = pc_m + 15'h0001 + {{6{a[8]}}, a[8:0]};
      default:
      begin
        pc_m = stk[sp_m[3:0]];
        sp_m = sp_m - 5'h01;
      end
    endcase
    notes.push_back({1'b0, 8'h00, pc_m, sp_m});
    u_pclu_partner.issue(k, a, w);
  endtask

  always @(posedge clk_sys_in) pend_q <= op_valid_in | reg_wr_en_in | reg_rd_en_in;
  always @(negedge clk_sys_in)
    if (pend_q === 1'b1)
    begin
      n = notes.pop_front();
      if (n.rd)
        chk("read data", {7'h00, reg_rd_data_out}, {7'h00, n.dat});
      else
      begin
        chk("pc", pc_out, n.pc);
        chk("sp", {10'h000, stack_pointer_out}, {10'h000, n.sp});
      end
    end

  initial
  begin
    #500000;
    fail_count++;
    test_done();
  end

  initial
  begin
    clk_sys_in = 1'b0;
    rst_b_in = 1'b0;
    reg_wr_en_in = 1'b0;
    reg_rd_en_in = 1'b0;
    reg_addr_in = 12'h000;
    reg_wr_data_in = 8'h00;
    dbg_mode_in = 1'b0;
    r = $random(seed);
    live_status_in = r[2:0];
    live_bank_in = r[7:3];
    live_ptr0_in = r[23:8];
    live_ptr1_in = r[31:16];
    pc_m = 15'h0000;
    sp_m = 5'h1f;
    lat_m = 7'h00;
    repeat (12) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    rd(12'hfed, 8'h1f);
    rd(12'h002, 8'h00);
    rd(12'h123, 8'h00);
    wr(12'h00a, 8'h12);
    wr(12'h002, 8'h34);
    rd(12'h002, 8'h34);
    op(PCLU_OP_BRA, 11'h1ff, 8'h00);
    op(PCLU_OP_BRA, 11'h100, 8'h00);
    for (int i = 0; i < 30; i++)
    begin
      r = $random(seed);
      wr(12'h00a, r[7:0]);
      op(PCLU_OP_CALL, r[18:8], r[26:19]);
      op(PCLU_OP_BRW, 11'h000, r[31:24]);
      op(PCLU_OP_BRA, r[10:0], 8'h00);
      op(PCLU_OP_COMPUTED_CALL_INSTR, 11'h000, r[15:8]);
      rd(12'hfee, stk[sp_m[3:0]][7:0]);
      rd(12'hfef, {1'b0, stk[sp_m[3:0]][14:8]});
      wr(12'h002, pc_m[7:0] + r[23:16]);
      op(PCLU_OP_RETURN, 11'h000, 8'h00);
      op(PCLU_OP_RETURN, 11'h000, 8'h00);
    end
    wr(12'hfed, 8'h04);
    rd(12'hfed, 8'h04);
    wr(12'hfe5, 8'ha5);
    rd(12'hfe5, 8'ha5);
    u_pclu_partner.dbg(1'b1, r[7:0]);
    lsh_m = lat_m;
    rd(12'hfe5, r[7:0]);
    rd(12'hfe6, 8'h00);
    dbg_mode_in = 1'b1;
    rd(12'hfe6, {3'h0, live_bank_in});
    wr(12'hfe7, 8'h55);
    dbg_mode_in = 1'b0;
    wr(12'hfe7, 8'h33);
    u_pclu_partner.dbg(1'b0, 8'h00);
    lat_m = lsh_m;
    chk("restore valid", {14'h0000, restore_valid_out}, 15'h0001);
    chk("restore w", {7'h00, restore_w_out}, {7'h00, r[7:0]});
    chk("latch", {8'h00, pc_high_latch_out}, {8'h00, lat_m});
    chk("restore status", {12'h000, restore_status_out}, {12'h000, live_status_in});
    chk("restore bank", {10'h000, restore_bank_out}, {10'h000, live_bank_in});
    chk("ptr0 low", {7'h00, restore_ptr0_out[7:0]}, {7'h00, live_ptr0_in[7:0]});
    chk("ptr0 high", {7'h00, restore_ptr0_out[15:8]}, {7'h00, live_ptr0_in[15:8]});
    chk("ptr1 low", {7'h00, restore_ptr1_out[7:0]}, {7'h00, live_ptr1_in[7:0]});
    chk("ptr1 high", {7'h00, restore_ptr1_out[15:8]}, {7'h00, live_ptr1_in[15:8]});
    wr(12'h002, 8'h00);
    repeat (2) @(negedge clk_sys_in);
    test_done();
  end
endmodule
